// ---- design/apr_consts.vh ----
`ifndef APR_CONSTS_VH
`define APR_CONSTS_VH

// sample word and slot geometry
`define APR_DW          16
`define APR_SLOT_CAP    5'h0f
`define APR_I2S_CAP     8'h10
`define APR_LJ_CAP      8'h0f
`define APR_TDM_LAST    8'hff

// format control word: format field position and codes
`define APR_FMT_MSB     5
`define APR_FMT_LSB     4
`define APR_FMT_I2S     2'h0
`define APR_FMT_TDM     2'h1
`define APR_FMT_RJ      2'h2
`define APR_FMT_LJ      2'h3
`define APR_FMT_RST     8'h00

// routing control word: first pair in bits 5:4, second pair in bits 1:0
`define APR_RTA_MSB     5
`define APR_RTA_LSB     4
`define APR_RTB_MSB     1
`define APR_RTB_LSB     0
`define APR_RT_MUTE     2'h0
`define APR_RT_LEFT     2'h1
`define APR_RT_RIGHT    2'h2
`define APR_RT_MIX      2'h3
`define APR_ROUTE_RST   8'h21

// filter engine
`define APR_LAST_STAGE  4'hb
`define APR_LAST_COEF   3'h4
`define APR_COEF_UNITY  16'sh4000
`define APR_QSH         14
`define APR_ALPHA_SH    4

// control port address, upper five bits fixed
`define APR_ADDR_HI     5'h13

// master clock timing: reference period and generated bit clock period
`define APR_CLK_NS      100
`define APR_MBCLK_NS    800
`define APR_MBCLK_HALF  ((`APR_MBCLK_NS) / (2 * `APR_CLK_NS))

`endif

// ---- design/apr_audio_port.v ----
`include "apr_consts.vh"

module apr_audio_port (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_i,
  // serial audio link
  input  wire        serial_bclk_i,
  output wire        serial_bclk_o,
  output wire        serial_bclk_oe_o,
  input  wire        serial_lrclk_i,
  output wire        serial_lrclk_o,
  output wire        serial_lrclk_oe_o,
  input  wire        serial_data_i,
  // control port fields
  input  wire        cfg_load_i,
  input  wire [7:0]  fmt_cfg_i,
  input  wire [7:0]  route_cfg_i,
  input  wire        master_en_i,
  input  wire        mono_en_i,
  input  wire        port_en_i,
  input  wire [2:0]  tdm_slot_l_i,
  input  wire [2:0]  tdm_slot_r_i,
  input  wire [1:0]  monitor_pin_sel_i,
  // processing coefficients
  input  wire        coef_we_i,
  input  wire [7:0]  coef_addr_i,
  input  wire [15:0] coef_data_i,
  input  wire [15:0] dynamic_level_equalizer_lo_i,
  input  wire [15:0] dynamic_level_equalizer_hi_i,
  input  wire [15:0] dynamic_range_compressor_lo_i,
  input  wire [15:0] dynamic_range_compressor_hi_i,
  input  wire [15:0] automatic_gain_limiter_i,
  // address select straps
  input  wire        address_select_high_i,
  input  wire        address_select_low_i,
  // speaker data and monitors
  output wire [15:0] speaker_pair_first_o,
  output wire [15:0] speaker_pair_second_o,
  output wire        sample_valid_o,
  output wire [15:0] level_meter_o,
  output wire [3:0]  general_purpose_pin_o,
  output wire [3:0]  general_purpose_pin_oe_o,
  output wire [6:0]  dev_addr_o
);

  // engine states
  localparam ST_IDLE  = 2'h0;
  localparam ST_MAC   = 2'h1;
  localparam ST_POST  = 2'h2;
  localparam ST_ROUTE = 2'h3;

  // saturate a shifted accumulator to a sample
  function signed [15:0] apr_sat;
    input signed [35:0] v;
    reg signed [35:0]   s;
    begin
      s = v >>> `APR_QSH;
      if (s > 36'sh0_0000_7fff)
        apr_sat = 16'sh7fff;
      else if (s < 36'shf_ffff_8000)
        apr_sat = 16'sh8000;
      else
        apr_sat = s[15:0];
    end
  endfunction

  // clip a value symmetrically to a positive threshold
  function signed [15:0] apr_clip;
    input signed [17:0] v;
    input        [15:0] t;
    reg   signed [17:0] tp;
    reg   signed [17:0] tn;
    begin
      tp = {2'b00, t};
      tn = -tp;
      if (v > tp)
        apr_clip = tp[15:0];
      else if (v < tn)
        apr_clip = tn[15:0];
      else
        apr_clip = v[15:0];
    end
  endfunction

  // choose routed data for one speaker pair
  function [15:0] apr_pick;
    input [1:0]  code;
    input [15:0] l;
    input [15:0] r;
    input [15:0] m;
    begin
      case (code)
        `APR_RT_LEFT:  apr_pick = l;
        `APR_RT_RIGHT: apr_pick = r;
        `APR_RT_MIX:   apr_pick = m;
        default:       apr_pick = 16'h0000;
      endcase
    end
  endfunction

  // latched configuration
  reg  [7:0]         fmt_reg;        // format control word
  reg  [7:0]         route_reg;      // routing control word
  reg                master_reg;     // clock master when set
  reg                mono_reg;       // parallel_bridged_mono when set
  // pin synchronisers: bclk, lrclk, data, straps
  wire [4:0]         pin_vec;
  reg  [4:0]         s1_reg;
  reg  [4:0]         s2_reg;
  reg  [4:0]         s3_reg;
  reg  [4:0]         filt_reg;       // accepted once stages two and three agree
  // master clock generator
  reg  [7:0]         div_reg;        // reference cycles within half bit
  reg                mbclk_reg;      // generated bit clock
  reg                mlr_reg;        // generated frame clock
  reg  [7:0]         mcnt_reg;       // bit position in generated frame
  reg                clk_oe_reg;     // clock pins driven
  wire [31:0]        half_m1_w;
  wire [7:0]         mcnt_next;
  wire               mlr_next;
  // receiver
  reg                bclk_prev_reg;
  reg                lr_smp_reg;     // frame clock at previous bit
  reg  [7:0]         bit_cnt_reg;    // bits since frame edge
  reg  [15:0]        shift_reg;
  reg  [15:0]        in_l_reg;
  reg  [15:0]        in_r_reg;
  reg                start_reg;      // one pulse per complete frame
  // filter engine
  reg  [1:0]         state_reg;
  reg                ch_reg;
  reg  [3:0]         stg_reg;
  reg  [2:0]         k_reg;
  reg  signed [35:0] acc_reg;
  reg  signed [15:0] xin_reg;        // input of current stage
  reg  signed [15:0] eq_l_reg;
  reg  signed [15:0] eq_r_reg;
  reg  signed [15:0] coef_mem [0:255];
  reg  signed [15:0] x1_mem [0:31];
  reg  signed [15:0] x2_mem [0:31];
  reg  signed [15:0] y1_mem [0:31];
  reg  signed [15:0] y2_mem [0:31];
  reg  signed [15:0] op;
  // output side
  reg  signed [15:0] mix_lp_reg;
  reg  [15:0]        spk_a_reg;
  reg  [15:0]        spk_b_reg;
  reg                valid_reg;
  reg  [15:0]        level_reg;
  reg  [31:0]        mon_shift_reg;  // serial_monitor_output word
  reg  [3:0]         gp_reg;
  reg  [3:0]         gp_oe_reg;
  reg  [6:0]         addr_reg;
  integer            i;              // coefficient store loop index
  integer            j;              // filter history loop index, kept apart from the store's

  // format, routing, master and mono fields take effect only on a control port load
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      fmt_reg    <= `APR_FMT_RST;
      route_reg  <= `APR_ROUTE_RST;
      master_reg <= 1'b0;
      mono_reg   <= 1'b0;
    end
    else if (cfg_load_i)
    begin
      fmt_reg    <= fmt_cfg_i;
      route_reg  <= route_cfg_i;
      master_reg <= master_en_i;
      mono_reg   <= mono_en_i;
    end
  end

  // three-stage synchronisers, one per pin
  assign pin_vec = {address_select_high_i, address_select_low_i, serial_data_i, serial_lrclk_i, serial_bclk_i};
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_sync
      always @(posedge ref_clk_i)
      begin
        if (rst_i)
        begin
          s1_reg[g]   <= 1'b0;
          s2_reg[g]   <= 1'b0;
          s3_reg[g]   <= 1'b0;
          filt_reg[g] <= 1'b0;
        end
        else
        begin
          s1_reg[g] <= pin_vec[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g])
            filt_reg[g] <= s3_reg[g];
        end
      end
    end
  endgenerate

  // format decode
  wire [1:0] fmt    = fmt_reg[`APR_FMT_MSB:`APR_FMT_LSB];
  wire       is_tdm = (fmt == `APR_FMT_TDM);

  // master frame: 64 bits, or 256 in tdm; frame clock per format
  assign half_m1_w = `APR_MBCLK_HALF - 1;
  assign mcnt_next = is_tdm ? mcnt_reg + 8'h01 : {2'b00, mcnt_reg[5:0] + 6'h01};
  assign mlr_next  = is_tdm ? (mcnt_next == 8'h00) :
                     (fmt == `APR_FMT_I2S) ? mcnt_next[5] : ~mcnt_next[5];

  // bit and frame clock divider, free running while master and enabled
  always @(posedge ref_clk_i)
  begin
    if (rst_i || !(master_reg && port_en_i))
    begin
      div_reg   <= 8'h00;
      mbclk_reg <= 1'b0;
      mlr_reg   <= 1'b0;
      mcnt_reg  <= 8'h00;
    end
    else if (div_reg == half_m1_w[7:0])
    begin
      div_reg   <= 8'h00;
      mbclk_reg <= ~mbclk_reg;
      if (mbclk_reg)
      begin
        mcnt_reg <= mcnt_next;
        mlr_reg  <= mlr_next;
      end
    end
    else
      div_reg <= div_reg + 8'h01;
  end

  // clock pin enables follow the master setting while the port is enabled
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
      clk_oe_reg <= 1'b0;
    else
      clk_oe_reg <= master_reg & port_en_i;
  end

  // clocks seen by the receiver: own in master, host's in slave
  wire bclk_cur  = master_reg ? mbclk_reg : filt_reg[0];
  wire lr_cur    = master_reg ? mlr_reg : filt_reg[1];
  wire data_cur  = filt_reg[2];
  wire bclk_rise = port_en_i & bclk_cur & ~bclk_prev_reg;
  wire lr_chg    = lr_cur ^ lr_smp_reg;
  wire frm_sync  = is_tdm ? (lr_cur & ~lr_smp_reg) : lr_chg;
  wire [7:0]  bit_idx = frm_sync ? 8'h00 : bit_cnt_reg;
  wire [15:0] word    = {shift_reg[14:0], data_cur};

  // serial receiver: sample on bit clock rise, capture per format
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      bclk_prev_reg <= 1'b0;
      lr_smp_reg    <= 1'b0;
      bit_cnt_reg   <= 8'h00;
      shift_reg     <= 16'h0000;
      in_l_reg      <= 16'h0000;
      in_r_reg      <= 16'h0000;
      start_reg     <= 1'b0;
    end
    else
    begin
      bclk_prev_reg <= bclk_cur;
      start_reg     <= 1'b0;
      if (bclk_rise)
      begin
        lr_smp_reg  <= lr_cur;
        shift_reg   <= word;
        bit_cnt_reg <= bit_idx + 8'h01;
        case (fmt)
          `APR_FMT_I2S:
            // one bit delay after the edge, low half is left
            if (bit_idx == `APR_I2S_CAP)
            begin
              if (lr_cur)
              begin
                in_r_reg  <= word;
                start_reg <= 1'b1;
              end
              else
                in_l_reg <= word;
            end
          `APR_FMT_LJ:
            // no delay, high half is left
            if (bit_idx == `APR_LJ_CAP)
            begin
              if (lr_cur)
                in_l_reg <= word;
              else
              begin
                in_r_reg  <= word;
                start_reg <= 1'b1;
              end
            end
          `APR_FMT_RJ:
            // last bits before the edge belong to the half just ended
            if (lr_chg)
            begin
              if (lr_smp_reg)
                in_l_reg <= shift_reg;
              else
              begin
                in_r_reg  <= shift_reg;
                start_reg <= 1'b1;
              end
            end
          default:
          begin
            // tdm: any slot may feed either channel
            if (bit_idx[4:0] == `APR_SLOT_CAP)
            begin
              if (bit_idx[7:5] == tdm_slot_l_i)
                in_l_reg <= word;
              if (bit_idx[7:5] == tdm_slot_r_i)
                in_r_reg <= word;
            end
            if (bit_idx == `APR_TDM_LAST)
              start_reg <= 1'b1;
          end
        endcase
      end
    end
  end

  // coefficient store, reset to pass-through
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      for (i = 0; i < 256; i = i + 1)
        coef_mem[i] <= (i % 8 == 0) ? `APR_COEF_UNITY : 16'sh0000;
    end
    else if (coef_we_i)
      coef_mem[coef_addr_i] <= coef_data_i;
  end

  // multiply-accumulate operand per coefficient slot
  wire [7:0] cidx = {ch_reg, stg_reg, k_reg};
  wire [4:0] sidx = {ch_reg, stg_reg};
  always @*
  begin
    case (k_reg)
      3'h0:    op = xin_reg;
      3'h1:    op = x1_mem[sidx];
      3'h2:    op = x2_mem[sidx];
      3'h3:    op = y1_mem[sidx];
      3'h4:    op = y2_mem[sidx];
      default: op = 16'sh0000;
    endcase
  end
  wire signed [31:0] prod    = coef_mem[cidx] * op;
  wire signed [35:0] acc_sum = acc_reg + {{4{prod[31]}}, prod};
  wire signed [15:0] y_sat   = apr_sat(acc_sum);

  // biquad engine: 2 channels x 12 stages x 5 products, one per cycle
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      ch_reg    <= 1'b0;
      stg_reg   <= 4'h0;
      k_reg     <= 3'h0;
      acc_reg   <= 36'sh0;
      xin_reg   <= 16'sh0000;
      eq_l_reg  <= 16'sh0000;
      eq_r_reg  <= 16'sh0000;
      for (j = 0; j < 32; j = j + 1)
      begin
        x1_mem[j] <= 16'sh0000;
        x2_mem[j] <= 16'sh0000;
        y1_mem[j] <= 16'sh0000;
        y2_mem[j] <= 16'sh0000;
      end
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          // a frame arriving while busy is dropped
          if (start_reg)
          begin
            xin_reg   <= in_l_reg;
            ch_reg    <= 1'b0;
            stg_reg   <= 4'h0;
            k_reg     <= 3'h0;
            acc_reg   <= 36'sh0;
            state_reg <= ST_MAC;
          end
        ST_MAC:
          if (k_reg == `APR_LAST_COEF)
          begin
            x2_mem[sidx] <= x1_mem[sidx];
            x1_mem[sidx] <= xin_reg;
            y2_mem[sidx] <= y1_mem[sidx];
            y1_mem[sidx] <= y_sat;
            acc_reg      <= 36'sh0;
            k_reg        <= 3'h0;
            if (stg_reg == `APR_LAST_STAGE)
            begin
              stg_reg <= 4'h0;
              if (ch_reg)
              begin
                eq_r_reg  <= y_sat;
                state_reg <= ST_POST;
              end
              else
              begin
                eq_l_reg <= y_sat;
                ch_reg   <= 1'b1;
                xin_reg  <= in_r_reg;
              end
            end
            else
            begin
              stg_reg <= stg_reg + 4'h1;
              xin_reg <= y_sat;
            end
          end
          else
          begin
            acc_reg <= acc_sum;
            k_reg   <= k_reg + 3'h1;
          end
        ST_POST:
          state_reg <= ST_ROUTE;
        ST_ROUTE:
          state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // per-channel level, dynamic equaliser, compressor and limiter
  wire [31:0] eq_bus = {eq_r_reg, eq_l_reg};
  wire [31:0] post_bus;
  wire [31:0] env_bus;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_ch
      reg  signed [15:0] env_reg;   // level envelope
      reg  signed [15:0] lp_reg;    // crossover low band
      reg  signed [15:0] post_reg;
      wire signed [15:0] x     = eq_bus[g*16 +: 16];
      wire signed [16:0] ax    = x[15] ? -{x[15], x} : {x[15], x};
      wire signed [16:0] env_d = (ax - {env_reg[15], env_reg}) >>> `APR_ALPHA_SH;
      wire signed [15:0] env_n = env_reg + env_d[15:0];
      wire signed [16:0] gdif  = {dynamic_level_equalizer_hi_i[15], dynamic_level_equalizer_hi_i} -
                                 {dynamic_level_equalizer_lo_i[15], dynamic_level_equalizer_lo_i};
      wire signed [32:0] gw    = gdif * $signed({1'b0, env_reg[14:0]});
      wire signed [15:0] gain  = dynamic_level_equalizer_lo_i + gw[30:15];
      wire signed [31:0] yp    = x * gain;
      wire signed [15:0] y     = apr_sat({{4{yp[31]}}, yp});
      wire signed [16:0] lp_d  = ({y[15], y} - {lp_reg[15], lp_reg}) >>> `APR_ALPHA_SH;
      wire signed [15:0] lp_n  = lp_reg + lp_d[15:0];
      wire signed [16:0] hi_b  = {y[15], y} - {lp_n[15], lp_n};
      wire signed [15:0] lo_c  = apr_clip({{2{lp_n[15]}}, lp_n}, dynamic_range_compressor_lo_i);
      wire signed [15:0] hi_c  = apr_clip({hi_b[16], hi_b}, dynamic_range_compressor_hi_i);
      wire signed [16:0] sum_b = {lo_c[15], lo_c} + {hi_c[15], hi_c};
      always @(posedge ref_clk_i)
      begin
        if (rst_i)
        begin
          env_reg  <= 16'sh0000;
          lp_reg   <= 16'sh0000;
          post_reg <= 16'sh0000;
        end
        else if (state_reg == ST_POST)
        begin
          env_reg  <= env_n;
          lp_reg   <= lp_n;
          post_reg <= apr_clip({sum_b[16], sum_b}, automatic_gain_limiter_i);
        end
      end
      assign post_bus[g*16 +: 16] = post_reg;
      assign env_bus[g*16 +: 16]  = env_reg;
    end
  endgenerate

  // left-right mixture through a first-order low-pass
  wire signed [15:0] pl       = post_bus[15:0];
  wire signed [15:0] pr       = post_bus[31:16];
  wire signed [16:0] mix_sum  = {pl[15], pl} + {pr[15], pr};
  wire signed [15:0] mix      = mix_sum[16:1];
  wire signed [16:0] mlp_d    = ({mix[15], mix} - {mix_lp_reg[15], mix_lp_reg}) >>> `APR_ALPHA_SH;
  wire signed [15:0] mix_lp_n = mix_lp_reg + mlp_d[15:0];
  wire [15:0] pick_a = apr_pick(route_reg[`APR_RTA_MSB:`APR_RTA_LSB], pl, pr, mix_lp_n);
  wire [15:0] pick_b = apr_pick(route_reg[`APR_RTB_MSB:`APR_RTB_LSB], pl, pr, mix_lp_n);

  // routing to the speaker pairs, meter and monitor word
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      mix_lp_reg    <= 16'sh0000;
      spk_a_reg     <= 16'h0000;
      spk_b_reg     <= 16'h0000;
      valid_reg     <= 1'b0;
      level_reg     <= 16'h0000;
      mon_shift_reg <= 32'h0000_0000;
    end
    else
    begin
      valid_reg <= 1'b0;
      if (state_reg == ST_ROUTE)
      begin
        mix_lp_reg <= mix_lp_n;
        spk_a_reg  <= pick_a;
        spk_b_reg  <= mono_reg ? pick_a : pick_b;
        valid_reg  <= 1'b1;
        level_reg  <= env_bus[15:0];
        mon_shift_reg <= {pick_a, mono_reg ? pick_a : pick_b};
      end
      else if (bclk_rise)
        mon_shift_reg <= {mon_shift_reg[30:0], 1'b0};
    end
  end

  // serial monitor steered onto the selected general_purpose_pin
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_pin
      always @(posedge ref_clk_i)
      begin
        if (rst_i)
        begin
          gp_reg[g]    <= 1'b0;
          gp_oe_reg[g] <= 1'b0;
        end
        else
        begin
          gp_reg[g]    <= (monitor_pin_sel_i == g) & mon_shift_reg[31];
          gp_oe_reg[g] <= (monitor_pin_sel_i == g) & port_en_i;
        end
      end
    end
  endgenerate

  // control port address from fixed prefix and select straps
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
      addr_reg <= 7'h00;
    else
      addr_reg <= {`APR_ADDR_HI, filt_reg[4], filt_reg[3]};
  end

  // output assignments, all from flops
  assign serial_bclk_o            = mbclk_reg;
  assign serial_bclk_oe_o         = clk_oe_reg;
  assign serial_lrclk_o           = mlr_reg;
  assign serial_lrclk_oe_o        = clk_oe_reg;
  assign speaker_pair_first_o     = spk_a_reg;
  assign speaker_pair_second_o    = spk_b_reg;
  assign sample_valid_o           = valid_reg;
  assign level_meter_o            = level_reg;
  assign general_purpose_pin_o    = gp_reg;
  assign general_purpose_pin_oe_o = gp_oe_reg;
  assign dev_addr_o               = addr_reg;

endmodule

// ---- tb/apr_audio_port_props.sv ----
module apr_audio_port_props (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // control fields
  input wire logic        cfg_load_i,
  input wire logic        mono_en_i,
  input wire logic        port_en_i,
  input wire logic [1:0]  monitor_pin_sel_i,
  // link clocks
  input wire logic        serial_bclk_o,
  input wire logic        serial_bclk_oe_o,
  input wire logic        serial_lrclk_o,
  input wire logic        serial_lrclk_oe_o,
  // outputs
  input wire logic [15:0] speaker_pair_first_o,
  input wire logic [15:0] speaker_pair_second_o,
  input wire logic        sample_valid_o,
  input wire logic [15:0] level_meter_o,
  input wire logic [3:0]  general_purpose_pin_o,
  input wire logic [3:0]  general_purpose_pin_oe_o,
  input wire logic [6:0]  dev_addr_o
);
  logic mono_reg; // mono choice as latched by the load strobe

  // follow the latched mono setting
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      mono_reg <= 1'b0;
    else if (cfg_load_i)
      mono_reg <= mono_en_i;
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_addr_fixed;
    dev_addr_o != 7'h0 |-> dev_addr_o[6:2] == 5'h13;
  endproperty
  a_addr_fixed: assert property (p_addr_fixed) else $error("fixed address bits wrong");
  property p_oe_pair;
    serial_bclk_oe_o == serial_lrclk_oe_o;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("clock enables differ");
  property p_bclk_half;
    serial_bclk_oe_o && $changed(serial_bclk_o) |=> ($stable(serial_bclk_o) || !serial_bclk_oe_o) [*3];
  endproperty
  a_bclk_half: assert property (p_bclk_half) else $error("bit clock half period short");
  property p_lr_edge;
    serial_lrclk_oe_o && $changed(serial_lrclk_o) |-> $fell(serial_bclk_o);
  endproperty
  a_lr_edge: assert property (p_lr_edge) else $error("frame clock moved off a falling bit clock");
  property p_bclk_run;
    serial_bclk_oe_o && port_en_i |-> ##[1:4] ($changed(serial_bclk_o) || !port_en_i || !serial_bclk_oe_o);
  endproperty
  a_bclk_run: assert property (p_bclk_run) else $error("bit clock stalled");
  property p_valid_pulse;
    sample_valid_o |=> !sample_valid_o;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid longer than one cycle");
  property p_mono_same;
    sample_valid_o && mono_reg |-> speaker_pair_first_o == speaker_pair_second_o;
  endproperty
  a_mono_same: assert property (p_mono_same) else $error("mono pairs differ");
  property p_out_stand;
    !sample_valid_o |-> $stable(speaker_pair_first_o) && $stable(speaker_pair_second_o);
  endproperty
  a_out_stand: assert property (p_out_stand) else $error("pair output moved without valid");
  property p_meter;
    $changed(level_meter_o) |-> sample_valid_o;
  endproperty
  a_meter: assert property (p_meter) else $error("meter moved without valid");
  property p_gp_pin;
    $past(port_en_i) && !$past(rst_i) |-> general_purpose_pin_oe_o == 4'h1 << $past(monitor_pin_sel_i)
      && (general_purpose_pin_o & ~general_purpose_pin_oe_o) == 4'h0;
  endproperty
  a_gp_pin: assert property (p_gp_pin) else $error("monitor pin choice wrong");
endmodule

bind apr_audio_port apr_audio_port_props i_props (.*);

// ---- tb/apr_host_model.sv ----
module apr_host_model (
  // serial link toward the device
  output logic bclk_o,
  output logic lrclk_o,
  output logic data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {bclk_o, lrclk_o, data_o} = 3'h0;

  // one frame; bit clock stands low between frames, data changes while low
  task automatic send(input logic [1:0] fmt, input logic [15:0] l, r, input logic [2:0] sl, sr);
    int n, h, j, p;
    logic [15:0] w;
    n = (fmt == 2'h1) ? 256 : 64;
    for (int i = 0; i < n; i++)
    begin
      h = i / 32;
      j = i % 32;
      if (fmt == 2'h1)
      begin
        w = (h == sl) ? l : (h == sr) ? r : 16'h0;
        lrclk_o = (i == 0);
        p = j;
      end
      else
      begin
        w = h ? r : l;
        lrclk_o = (fmt == 2'h0) ? h[0] : !h[0];
        p = (fmt == 2'h0) ? j - 1 : (fmt == 2'h2) ? j - 16 : j;
      end
      data_o = (p >= 0 && p < 16) ? w[15 - p] : !data_o;
      #400 bclk_o = 1'b1;
      #400 bclk_o = 1'b0;
    end
    data_o = !data_o; // released line shows no stale value
  endtask
endmodule

// ---- tb/apr_audio_port_bench.sv ----
module apr_audio_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 0, rst_i = 1, cfg_load_i = 0, master_en_i = 0, mono_en_i = 0, port_en_i = 0, coef_we_i = 0;
  logic address_select_high_i = 1, address_select_low_i = 0;
  logic [7:0] fmt_cfg_i = 0, route_cfg_i = 8'h21, coef_addr_i = 0;
  logic [2:0] tdm_slot_l_i = 0, tdm_slot_r_i = 0;
  logic [1:0] monitor_pin_sel_i = 0;
  logic [15:0] coef_data_i = 0, dynamic_level_equalizer_lo_i = 16'h4000, dynamic_level_equalizer_hi_i = 16'h4000;
  logic [15:0] dynamic_range_compressor_lo_i = 16'h7fff, dynamic_range_compressor_hi_i = 16'h7fff;
  logic [15:0] automatic_gain_limiter_i = 16'h7fff;
  wire serial_bclk_i, serial_bclk_o, serial_bclk_oe_o, serial_lrclk_i, serial_lrclk_o, serial_lrclk_oe_o;
  wire serial_data_i, sample_valid_o, h_bclk, h_lr;
  wire [15:0] speaker_pair_first_o, speaker_pair_second_o, level_meter_o;
  wire [3:0] general_purpose_pin_o, general_purpose_pin_oe_o;
  wire [6:0] dev_addr_o;
  int err_total = 0, cmp_count = 0, n, m;
  logic pb, pl; // master clock levels at the previous falling edge
  logic [15:0] sv[3];
  // shared link wires: device drives when its enable is high
  assign serial_bclk_i = serial_bclk_oe_o ? serial_bclk_o : h_bclk;
  assign serial_lrclk_i = serial_lrclk_oe_o ? serial_lrclk_o : h_lr;

  apr_audio_port i_dut (.*);
  apr_host_model i_host (.bclk_o(h_bclk), .lrclk_o(h_lr), .data_o(serial_data_i));

  initial forever #50 ref_clk_i = ~ref_clk_i;

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, s);
    cmp_count++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      err_total++;
    end
  endtask

  task automatic cfg(input logic [7:0] f, rt, input logic ms, mo);
    @(negedge ref_clk_i);
    {fmt_cfg_i, route_cfg_i, master_en_i, mono_en_i, cfg_load_i} = {f, rt, ms, mo, 1'b1};
    @(negedge ref_clk_i);
    cfg_load_i = 0;
  endtask

  // three frames so every framing has a closing edge, then the engine latency
  task automatic xfer(input logic [1:0] f);
    repeat (3) i_host.send(f, sv[1], sv[2], tdm_slot_l_i, tdm_slot_r_i);
    repeat (300) @(negedge ref_clk_i);
  endtask

  task automatic pairs(input logic [15:0] a, b);
    chk("first pair", a, speaker_pair_first_o);
    chk("second pair", b, speaker_pair_second_o);
  endtask

  initial
  begin
    sv = '{16'h0, 16'h1234, 16'h0567};
    repeat (16) @(negedge ref_clk_i);
    chk("first in reset", 16'h0, speaker_pair_first_o);
    {rst_i, port_en_i} = 2'b01;
    repeat (8) @(negedge ref_clk_i);
    chk("address", {9'h0, 5'h13, 2'b10}, dev_addr_o);
    {address_select_high_i, address_select_low_i} = 2'b01;
    repeat (8) @(negedge ref_clk_i);
    chk("address", {9'h0, 5'h13, 2'b01}, dev_addr_o);
    xfer(2'h0);
    pairs(sv[2], sv[1]);
    for (int k = 0; k < 3; k++)
    begin
      cfg(8'h0, {2'h0, 2'(k), 2'h0, 2'(2 - k)}, 0, 0);
      xfer(2'h0);
      pairs(sv[k], sv[2 - k]);
    end
    for (int k = 1; k < 4; k++)
    begin
      cfg(8'h0, {2'h0, 2'(k), 4'h0}, 0, 1);
      xfer(2'h0);
      chk("mono", speaker_pair_first_o, speaker_pair_second_o);
      if (k < 3)
        chk("mono source", sv[k], speaker_pair_first_o);
    end
    {tdm_slot_l_i, tdm_slot_r_i} = {3'h5, 3'h2};
    for (int f = 1; f < 4; f++)
    begin
      cfg(8'(f << 4), 8'h21, 0, 0);
      xfer(2'(f));
      pairs(sv[2], sv[1]);
    end
    cfg(8'h0, 8'h21, 1, 0);
    repeat (16) @(negedge ref_clk_i);
    chk("clock drive", 16'h1, {15'h0, serial_bclk_oe_o});
    n = 0;
    m = 0;
    pb = serial_bclk_o;
    pl = serial_lrclk_o;
    for (int c = 0; c < 320; c++)
    begin
      @(negedge ref_clk_i);
      n += (serial_bclk_o !== pb);
      m += (serial_lrclk_o !== pl);
      pb = serial_bclk_o;
      pl = serial_lrclk_o;
    end
    chk("clock edges", 16'd80, 16'(n));
    chk("frame edges", 16'd1, 16'(m));
    cfg(8'h0, 8'h21, 0, 0);
    for (int s = 0; s < 4; s++)
    begin
      @(negedge ref_clk_i);
      monitor_pin_sel_i = 2'(s);
      repeat (3) @(negedge ref_clk_i);
      chk("monitor pin", 16'h1 << s, {12'h0, general_purpose_pin_oe_o});
    end
    {coef_we_i, coef_addr_i, coef_data_i} = {1'b1, 8'h00, 16'h2000};
    @(negedge ref_clk_i);
    coef_we_i = 0;
    xfer(2'h0);
    pairs(sv[2], 16'h091a);
    test_done();
  end
endmodule
